// ===== design/tmr_pkg.sv
package tmr_pkg;

  // channel counts and widths
  localparam int NA         = 5;
  localparam int NB         = 6;
  localparam int CNT_W      = 16;
  localparam int ADDR_W     = 8;
  localparam int REG_STRIDE = 4;
  localparam int NTICK      = 4;
  localparam int STS_W      = NA + NB;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_START     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EXT_START = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STOP_POL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CUTOFF    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_A_MODE    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_A_CNT     = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_B_MODE    = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_B_CNT     = 8'h80;

  // field positions
  localparam int A_RUN_LSB   = 0;
  localparam int B_RUN_LSB   = 8;
  localparam int EXT_RUN_LSB = 0;
  localparam int CUT_EN_BIT  = 0;
  localparam int SD_LVL_BIT  = 1;
  localparam int MODE_LSB    = 0;
  localparam int SRC_LSB     = 2;
  localparam int DUTY_LSB    = 0;
  localparam int PER_LSB     = 16;

  // operating modes of the pwm-capable channels
  localparam logic [1:0] MODE_TIMER   = 2'h0;
  localparam logic [1:0] MODE_EVENT   = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_PWM     = 2'h3;

  // count source taps on the shared prescaler: /1, /8, /32, /256
  localparam logic [NTICK-1:0][7:0] TICK_MASK = {8'hff, 8'h1f, 8'h07, 8'h00};

  localparam logic [NA-1:0]    CUT_CH_MASK  = 5'h16;
  localparam logic [CNT_W-1:0] RELOAD_READ  = 16'hffff;
  localparam logic [2:0]       SD_SYNC_RST  = 3'h7;

  typedef struct packed {
    logic [NA-1:0]                a_run;
    logic [NB-1:0]                b_run;
    logic [NA-1:0]                pol;
    logic                         cut_en;
    logic [STS_W-1:0]             sts;
    logic [STS_W-1:0]             msk;
    logic [NA-1:0][1:0]           a_mode;
    logic [NA-1:0][1:0]           a_src;
    logic [NA-1:0][CNT_W-1:0]     a_duty;
    logic [NA-1:0][CNT_W-1:0]     a_per;
    logic [NA-1:0][CNT_W-1:0]     a_cnt;
    logic [NA-1:0]                a_out;
    logic [NB-1:0][1:0]           b_src;
    logic [7:0]                   pre;
    logic [2:0]                   sd_sync;
    logic                         sd_lvl;
    logic                         dp_wr;
    logic [ADDR_W-1:0]            dp_addr;
    logic [31:0]                  rdata;
  } tmr_state_type;

  localparam tmr_state_type STATE_RST = '{sd_sync: SD_SYNC_RST, sd_lvl: 1'b1, default: '0};

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rld;
  } tmr_bchan_type;

endpackage : tmr_pkg

// ===== design/tmr_bchan_if.sv
`timescale 1ns/1ps
interface tmr_bchan_if import tmr_pkg::*; ();
  logic             run;
  logic             tick;
  logic             wr;
  logic [CNT_W-1:0] wdata;
  logic [CNT_W-1:0] cnt;
  logic             reload;

  modport ctl  (output run, output tick, output wr, output wdata, input cnt, input reload);
  modport chan (input run, input tick, input wr, input wdata, output cnt, output reload);
endinterface : tmr_bchan_if

// ===== design/tmr_bchan.sv
`timescale 1ns/1ps
module tmr_bchan import tmr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and counter view
  tmr_bchan_if.chan ch
);

  tmr_bchan_type q;
  tmr_bchan_type d;
  logic          rl;

  // reload happens on the tick that finds the counter at zero
  assign rl = ch.run && ch.tick && (q.cnt == '0);

  always_comb begin
    d = q;
    if (ch.wr) begin
      d.rld = ch.wdata;
      if (!ch.run) begin
        d.cnt = ch.wdata;
      end
    end
    if (rl) begin
      d.cnt = q.rld;
    end else if (ch.run && ch.tick) begin
      d.cnt = q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ch.cnt    = q.cnt;
  assign ch.reload = rl;

  AST_WRITE_WHILE_STOPPED: assert property (@(posedge clk) disable iff (rst)
    (ch.wr && !ch.run) |=> (q.cnt == $past(ch.wdata)))
    else $error("counter does not hold the value written while stopped");

  AST_HALTED_HOLDS: assert property (@(posedge clk) disable iff (rst)
    (!ch.run && !ch.wr) |=> $stable(q.cnt))
    else $error("stopped counter moved");

endmodule : tmr_bchan

// ===== design/tmr_timer_top.sv
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
//
// Overview of operation
// - After reset all pwm and interval channels are stopped.
// - A pwm channel counts only after software sets its start bit.
// - Selecting pwm mode from timer or event counter mode sets the request flag.
// - Stop in pwm mode with polarity 0: counter halts, high output goes low and sets flag.
// - Stop in pwm mode with polarity 1: counter halts, low output goes high and sets flag.
// - Cutoff enabled and shutdown input low floats pwm outputs 1, 2 and 4.
// - An interval channel counts only after either start register sets its bit.
// - Reading an interval counter returns its live value.
// - A read coinciding with a counter reload returns all ones.
// - A value written while stopped reads back until counting starts.
module tmr_timer_top import tmr_pkg::*; (
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // pins
  input  wire logic        SHUTDOWN_N,
  output logic [NA-1:0]    PWM_OUT,
  output logic [NA-1:0]    PWM_OE,
  // interrupt
  output logic             IRQ
);

  tmr_state_type               q;
  tmr_state_type               d;
  logic [NTICK-1:0]            ticks;
  logic [NB-1:0][CNT_W-1:0]    b_cnt;
  logic [NB-1:0]               b_rld;
  logic [STS_W-1:0]            ev;
  logic                        acc;
  logic                        tk;
  logic [ADDR_W-1:0]           ra;
  logic [ADDR_W-1:0]           wa;
  logic [ADDR_W-1:0]           ofs;
  logic                        after_rst_q;

  // only whole-word transfers are expected, so hsize is not decoded
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign ra  = HADDR[ADDR_W-1:0];
  assign wa  = q.dp_addr;

  genvar gk;
  generate
    for (gk = 0; gk < NTICK; gk++) begin : g_tick
      assign ticks[gk] = ((q.pre & TICK_MASK[gk]) == TICK_MASK[gk]);
    end
  endgenerate

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_b
      tmr_bchan_if bif ();
      assign bif.run   = q.b_run[gb];
      assign bif.tick  = ticks[q.b_src[gb]];
      assign bif.wr    = q.dp_wr && (wa == OFS_B_CNT + 8'(gb * REG_STRIDE));
      assign bif.wdata = HWDATA[CNT_W-1:0];
      assign b_cnt[gb] = bif.cnt;
      assign b_rld[gb] = bif.reload;
      tmr_bchan tmr_bchan_inst (
        .clk (CLK_SYS),
        .rst (SYS_RST),
        .ch  (bif.chan)
      );
    end
  endgenerate

  always_comb begin
    d       = q;
    ev      = '0;
    tk      = 1'b0;
    ofs     = '0;
    d.pre   = q.pre + 8'h01;
    d.dp_wr = acc && HWRITE;
    if (acc) begin
      d.dp_addr = ra;
    end
    // only the second and third stages are compared; the first one may be metastable
    d.sd_sync = {q.sd_sync[1:0], SHUTDOWN_N};
    if (q.sd_sync[2] == q.sd_sync[1]) begin
      d.sd_lvl = q.sd_sync[1];
    end

    // pwm counting
    for (int i = 0; i < NA; i++) begin
      tk = ticks[q.a_src[i]];
      if (q.a_run[i] && tk) begin
        if (q.a_cnt[i] == q.a_per[i]) begin
          d.a_cnt[i] = '0;
          ev[i]      = 1'b1;
        end else begin
          d.a_cnt[i] = q.a_cnt[i] + 16'h0001;
        end
        if (q.a_mode[i] == MODE_PWM) begin
          d.a_out[i] = (d.a_cnt[i] < q.a_duty[i]);
        end
      end
    end

    // data-phase writes
    if (q.dp_wr) begin
      case (wa)
        OFS_START: begin
          d.a_run = HWDATA[A_RUN_LSB +: NA];
          d.b_run = HWDATA[B_RUN_LSB +: NB];
        end
        OFS_EXT_START: d.b_run = HWDATA[EXT_RUN_LSB +: NB];
        OFS_STOP_POL:  d.pol    = HWDATA[NA-1:0];
        OFS_CUTOFF:    d.cut_en = HWDATA[CUT_EN_BIT];
        OFS_MASK:      d.msk    = HWDATA[STS_W-1:0];
        default: ;
      endcase
      // mode changes are not blocked while running; software is trusted to stop first
      for (int i = 0; i < NA; i++) begin
        if (wa == OFS_A_MODE + 8'(i * REG_STRIDE)) begin
          d.a_mode[i] = HWDATA[MODE_LSB +: 2];
          d.a_src[i]  = HWDATA[SRC_LSB +: 2];
          if (HWDATA[MODE_LSB +: 2] == MODE_PWM &&
              (q.a_mode[i] == MODE_TIMER || q.a_mode[i] == MODE_EVENT)) begin
            ev[i] = 1'b1;
          end
        end
        if (wa == OFS_A_CNT + 8'(i * REG_STRIDE)) begin
          d.a_duty[i] = HWDATA[DUTY_LSB +: CNT_W];
          d.a_per[i]  = HWDATA[PER_LSB +: CNT_W];
        end
      end
      for (int i = 0; i < NB; i++) begin
        if (wa == OFS_B_MODE + 8'(i * REG_STRIDE)) begin
          d.b_src[i] = HWDATA[SRC_LSB +: 2];
        end
      end
    end

    // stop during pwm output drives the idle level chosen by the polarity bit
    // a tick landing in the stop cycle still counts; the counter is frozen from the next cycle on
    for (int i = 0; i < NA; i++) begin
      if (q.a_run[i] && !d.a_run[i] && q.a_mode[i] == MODE_PWM) begin
        d.a_out[i] = q.a_out[i];
        if (!q.pol[i] && q.a_out[i]) begin
          d.a_out[i] = 1'b0;
          ev[i]      = 1'b1;
        end else if (q.pol[i] && !q.a_out[i]) begin
          d.a_out[i] = 1'b1;
          ev[i]      = 1'b1;
        end
      end
    end

    ev[NA +: NB] = b_rld;
    // write-one-to-clear, but a same-cycle event still lands
    if (q.dp_wr && wa == OFS_STATUS) begin
      d.sts = q.sts & ~HWDATA[STS_W-1:0];
    end
    d.sts = d.sts | ev;

    // address-phase read, registered for the data phase; unmapped reads give zero
    d.rdata = '0;
    if (acc && !HWRITE) begin
      case (ra)
        OFS_START: begin
          d.rdata[A_RUN_LSB +: NA] = q.a_run;
          d.rdata[B_RUN_LSB +: NB] = q.b_run;
        end
        OFS_EXT_START: d.rdata[EXT_RUN_LSB +: NB] = q.b_run;
        OFS_STOP_POL:  d.rdata[NA-1:0] = q.pol;
        OFS_CUTOFF: begin
          d.rdata[CUT_EN_BIT] = q.cut_en;
          d.rdata[SD_LVL_BIT] = q.sd_lvl;
        end
        OFS_STATUS: d.rdata[STS_W-1:0] = q.sts;
        OFS_MASK:   d.rdata[STS_W-1:0] = q.msk;
        default: ;
      endcase
      for (int i = 0; i < NA; i++) begin
        ofs = 8'(i * REG_STRIDE);
        if (ra == OFS_A_MODE + ofs) begin
          d.rdata[MODE_LSB +: 2] = q.a_mode[i];
          d.rdata[SRC_LSB +: 2]  = q.a_src[i];
        end
        if (ra == OFS_A_CNT + ofs) begin
          d.rdata[DUTY_LSB +: CNT_W] = q.a_duty[i];
          d.rdata[PER_LSB +: CNT_W]  = q.a_per[i];
        end
      end
      for (int i = 0; i < NB; i++) begin
        ofs = 8'(i * REG_STRIDE);
        if (ra == OFS_B_MODE + ofs) begin
          d.rdata[SRC_LSB +: 2] = q.b_src[i];
        end
        if (ra == OFS_B_CNT + ofs) begin
          d.rdata[CNT_W-1:0] = b_rld[i] ? RELOAD_READ : b_cnt[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      after_rst_q <= 1'b1;
    end else begin
      after_rst_q <= 1'b0;
    end
  end

  assign HRDATA    = q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign PWM_OUT   = q.a_out;
  assign PWM_OE    = ~({NA{q.cut_en & ~q.sd_lvl}} & CUT_CH_MASK);
  assign IRQ       = |(q.sts & q.msk);

  AST_STOPPED_AFTER_RESET: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    after_rst_q |-> (q.a_run == '0 && q.b_run == '0))
    else $error("a channel runs right after reset");

  AST_START_BY_WRITE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (|(q.a_run & ~$past(q.a_run))) |-> $past(q.dp_wr && q.dp_addr == OFS_START))
    else $error("pwm channel started without a start write");

  AST_B_START_BY_WRITE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (|(q.b_run & ~$past(q.b_run))) |->
      $past(q.dp_wr && (q.dp_addr == OFS_START || q.dp_addr == OFS_EXT_START)))
    else $error("interval channel started without a start write");

  AST_PWM_SELECT_FLAG: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.dp_wr && wa == OFS_A_MODE && HWDATA[MODE_LSB +: 2] == MODE_PWM &&
     (q.a_mode[0] == MODE_TIMER || q.a_mode[0] == MODE_EVENT)) |=> q.sts[0])
    else $error("selecting pwm mode did not set the request flag");

  AST_STOP_POL_LOW: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.a_mode[0] == MODE_PWM && q.a_run[0] && !d.a_run[0] && !q.pol[0]) |=>
      (!q.a_out[0] && !q.a_run[0] && (!$past(q.a_out[0]) || q.sts[0])) ##1 $stable(q.a_cnt[0]))
    else $error("stop with polarity 0 gave the wrong level or flag");

  AST_STOP_POL_HIGH: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.a_mode[0] == MODE_PWM && q.a_run[0] && !d.a_run[0] && q.pol[0]) |=>
      (q.a_out[0] && !q.a_run[0] && ($past(q.a_out[0]) || q.sts[0])) ##1 $stable(q.a_cnt[0]))
    else $error("stop with polarity 1 gave the wrong level or flag");

  AST_FORCED_CUTOFF: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.cut_en && !SHUTDOWN_N) [*3] ##2 q.cut_en |-> ((PWM_OE & CUT_CH_MASK) == '0))
    else $error("shutdown input did not float the cut-off outputs");

  AST_LIVE_READ: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (acc && !HWRITE && ra == OFS_B_CNT && !b_rld[0]) |=> (HRDATA[CNT_W-1:0] == $past(b_cnt[0])))
    else $error("counter read is not the live value");

  AST_RELOAD_READ: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (acc && !HWRITE && ra == OFS_B_CNT && b_rld[0]) |=> (HRDATA[CNT_W-1:0] == RELOAD_READ))
    else $error("read during reload did not return all ones");

  AST_PWM_HALTED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.a_run == '0) |=> $stable(q.a_cnt))
    else $error("stopped pwm counter moved");

  AST_A_START_BITS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.dp_wr && wa == OFS_START) |=> (q.a_run == $past(HWDATA[A_RUN_LSB +: NA])))
    else $error("pwm start bits do not follow the start write");

  AST_B_HALTED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.b_run == '0 && !q.dp_wr) |=> $stable(b_cnt))
    else $error("stopped interval counter moved");

  AST_EXT_START_BITS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (q.dp_wr && wa == OFS_EXT_START) |=> (q.b_run == $past(HWDATA[EXT_RUN_LSB +: NB])))
    else $error("interval start bits do not follow the extended start write");

  COV_PWM_STOP: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    q.a_mode[0] == MODE_PWM && q.a_run[0] ##1 !q.a_run[0]);

  COV_RELOAD_READ: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    acc && !HWRITE && ra == OFS_B_CNT && b_rld[0]);

  COV_CUTOFF: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    q.cut_en && !q.sd_lvl);

  COV_IRQ: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(IRQ));

  COV_PWM_SELECT: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    q.dp_wr && wa == OFS_A_MODE && HWDATA[MODE_LSB +: 2] == MODE_PWM);

endmodule : tmr_timer_top

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  import tmr_pkg::*;

  logic           clk;
  logic           rst;
  logic           hsel;
  logic [31:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [31:0]    hwdata;
  logic           shutdown_n;
  wire  [31:0]    hrdata;
  wire            hready;
  wire            hresp;
  wire  [NA-1:0]  pwm_out;
  wire  [NA-1:0]  pwm_oe;
  wire            irq;
  int             err_total;
  int             n_compared;
  logic [31:0]    rd;
  logic [31:0]    rd2;
  int             hits;

  tmr_timer_top tmr_timer_top_inst (
    .CLK_SYS    (clk),
    .SYS_RST    (rst),
    .HSEL       (hsel),
    .HADDR      (haddr),
    .HTRANS     (htrans),
    .HWRITE     (hwrite),
    .HSIZE      (3'h2),
    .HWDATA     (hwdata),
    .HREADY     (hready),
    .HRDATA     (hrdata),
    .HREADYOUT  (hready),
    .HRESP      (hresp),
    .SHUTDOWN_N (shutdown_n),
    .PWM_OUT    (pwm_out),
    .PWM_OE     (pwm_oe),
    .IRQ        (irq)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // waits for hready at a rising edge; a missing answer counts as a hang
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_total++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rdc

  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    err_total  = 0;
    n_compared = 0;
    rst        = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    shutdown_n = 1'b1;
    tick(10);
    rst <= 1'b0;
    // everything idle after reset
    rdc(OFS_START, 32'h0);
    rdc(OFS_EXT_START, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_MASK, 32'h0);
    rdc(8'hfc, 32'h0);
    check({26'h0, irq, pwm_out}, 32'h0);
    check({27'h0, pwm_oe}, 32'h1f);
    check({30'h0, hresp, hready}, 32'h1);

    // mode changes into pwm from timer and event modes raise the flag
    wr(OFS_A_MODE + 8'h04, {30'h0, MODE_EVENT});
    for (int i = 0; i < 3; i++) begin
      wr(OFS_A_MODE + 8'(4 * i), {30'h0, MODE_PWM});
    end
    rdc(OFS_STATUS, 32'h7);
    wr(OFS_STATUS, 32'h7);
    rdc(OFS_STATUS, 32'h0);
    // one-shot to pwm is not one of the flag-raising changes
    wr(OFS_A_MODE + 8'h0c, {30'h0, MODE_ONESHOT});
    wr(OFS_A_MODE + 8'h0c, {30'h0, MODE_PWM});
    rdc(OFS_STATUS, 32'h0);

    // ch0 always high, ch1 and ch2 always low; period long enough that no wrap occurs
    wr(OFS_A_CNT, 32'hffffffff);
    wr(OFS_A_CNT + 8'h04, 32'hffff0000);
    wr(OFS_A_CNT + 8'h08, 32'hffff0000);
    wr(OFS_STOP_POL, 32'h2);
    tick(5);
    check({27'h0, pwm_out}, 32'h0);
    wr(OFS_START, 32'h7);
    tick(5);
    check({29'h0, pwm_out[2:0]}, 32'h1);
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_START, 32'h0);
    tick(2);
    check({29'h0, pwm_out[2:0]}, 32'h2);
    rdc(OFS_STATUS, 32'h3);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h3);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0);

    // forced cutoff floats only pins 1, 2 and 4, and only when enabled
    shutdown_n <= 1'b0;
    tick(8);
    check({27'h0, pwm_oe}, 32'h1f);
    rdc(OFS_CUTOFF, 32'h0);
    wr(OFS_CUTOFF, 32'h1);
    tick(6);
    check({27'h0, pwm_oe}, 32'h09);
    shutdown_n <= 1'b1;
    tick(8);
    rdc(OFS_CUTOFF, 32'h3);
    check({27'h0, pwm_oe}, 32'h1f);
    wr(OFS_CUTOFF, 32'h0);

    // interval channel 0: value written while stopped holds until start
    wr(OFS_B_MODE, 32'h0);
    wr(OFS_B_CNT, 32'h4);
    tick(20);
    rdc(OFS_B_CNT, 32'h4);
    wr(OFS_EXT_START, 32'h1);
    // reads every third cycle against a five-cycle round reach every phase
    hits = 0;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, OFS_B_CNT, 32'h0, rd);
      if (rd === 32'h0000ffff) begin
        hits++;
      end else begin
        check({31'h0, rd <= 32'h4}, 32'h1);
      end
    end
    check({31'h0, hits > 0}, 32'h1);
    wr(OFS_EXT_START, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    check({31'h0, rd[NA]}, 32'h1);

    // interval channel 1 started from the main start register, then halted
    wr(OFS_B_CNT + 8'h04, 32'h3);
    wr(OFS_START, 32'h200);
    tick(4);
    wr(OFS_START, 32'h0);
    bus(1'b0, OFS_B_CNT + 8'h04, 32'h0, rd);
    check({31'h0, rd <= 32'h3}, 32'h1);
    tick(10);
    bus(1'b0, OFS_B_CNT + 8'h04, 32'h0, rd2);
    check(rd2, rd);
    // only the reload flag of interval channel 1 is unmasked
    wr(OFS_MASK, 32'h40);
    tick(2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h7ff);
    tick(2);
    check({31'h0, irq}, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    wrap_up();
  end
endmodule : tb
